/* File: hw/sar_port_pkg.sv */
// Package: constants and carrier types for the converter host port
package sar_port_pkg;
    localparam int          RESULT_WIDTH     = 16;
    localparam int          BYTE_WIDTH       = 8;
    localparam int          CLK_PERIOD_NS    = 40;
    // Least low time of the combined start, in ns
    localparam int          START_LOW_NS     = 40;
    localparam int          START_LOW_CYCLES =
        (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Modelled conversion length in clock cycles
    localparam int          CONV_CYCLES      = 100;
    localparam logic [15:0] RESULT_RESET     = 16'h0000;

    // Synchronised host controls
    typedef struct packed {
        logic selN;
        logic readConv;
        logic byteSel;
    } hostCtl_t;

    // Parallel bus drive
    typedef struct packed {
        logic [15:0] data;
        logic [15:0] oe;
    } busDrive_t;
endpackage : sar_port_pkg

/* File: hw/pin_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } syncState_t;

    syncState_t state_q;
    syncState_t state_d;

    // Stage one feeds only stage two
    always_comb begin
        state_d        = state_q;
        state_d.stage1 = pinIn;
        state_d.stage2 = state_q.stage1;
    end

    // Inactive-high reset value keeps the port idle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '1;
        end else begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.stage2;
endmodule : pin_sync

/* File: hw/sar_adc_parallel_host_port.sv */
// Control and parallel readout port of a 16-bit successive-approximation converter
// Operation
// RQ1: Busy low from conversion start until result register updated.
// RQ2: Select and read/convert are ORed; either can trigger the other.
// RQ3: With read/convert low, select falling edge starts a conversion.
// RQ4: With select low and busy high, read/convert falling starts conversion.
// RQ5: With select low, read/convert rising edge enables the output bus.
// RQ6: Output bus floats while select high or read/convert low.
// RQ7: Result MSB on data bit 15, LSB on data bit 0.
// RQ8: Byte mode: select low gives upper byte, high gives lower byte.
// RQ9: Result is coded in binary two's complement.
// RQ10: Convert command during busy aborts and restarts converter logic.
// RQ11: Host holds both inputs low at least 40 ns to start.
// RQ12: Conversion ends after fixed cycles; register updates before busy rises.
`timescale 1ns/1ns
module sar_adc_parallel_host_port
    import sar_port_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Host controls, asynchronous pins
    input  wire logic        selN,
    input  wire logic        readConv,
    input  wire logic        byteSel,
    // Sampled analog value, two's complement code from the front end
    input  wire logic [15:0] sampleCode,
    // Status
    output logic             busyN,
    // Parallel result bus, three signals per pin
    input  wire logic [15:0] resultDataIn,
    output logic      [15:0] resultDataOut,
    output logic      [15:0] resultDataOe
);
    typedef enum logic [1:0] {IDLE, QUALIFY, CONVERT, UPDATE} phase_t;

    typedef struct packed {
        phase_t      phase;
        logic        startPrev;
        logic        readPrev;
        logic [15:0] count;
        logic [15:0] held;
        logic [15:0] result;
        logic        busyN;
        busDrive_t   bus;
    } portState_t;

    portState_t state_q;
    portState_t state_d;
    hostCtl_t   ctl;
    logic [2:0] syncVec;
    logic       startLow;
    logic       startFall;
    logic       readRise;
    logic       outEn;

    // Pins cross into mclk before any decode
    pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .pinIn   ({selN, readConv, byteSel}),
        .syncOut (syncVec)
    );
    assign ctl = hostCtl_t'(syncVec);

    // OR of active-low inputs: low only when both are low
    assign startLow  = ctl.selN | ctl.readConv;             // see RQ2
    // A falling combined level is select falling with r/c low or vice versa
    assign startFall = state_q.startPrev & ~startLow;       // see RQ3 see RQ4
    assign readRise  = ~state_q.readPrev & ctl.readConv & ~ctl.selN; // see RQ5
    assign outEn     = ~ctl.selN & ctl.readConv;            // see RQ6

    // Next state
    always_comb begin
        state_d           = state_q;
        state_d.startPrev = startLow;
        state_d.readPrev  = ctl.readConv;
        case (state_q.phase)
            IDLE: begin
                if (startFall) begin
                    // Hold the sample at the instant of the command
                    state_d.held  = sampleCode;                 // see RQ9
                    state_d.count = 16'(START_LOW_CYCLES);
                    state_d.phase = QUALIFY;
                end
            end
            QUALIFY: begin
                // Short glitches below the least low time are dropped
                if (startLow) begin
                    state_d.phase = IDLE;                       // see RQ11
                end else if (state_q.count <= 16'(START_LOW_CYCLES)) begin
                    state_d.busyN = 1'b0;                       // see RQ1
                    state_d.count = 16'(CONV_LEN);
                    state_d.phase = CONVERT;
                end
            end
            CONVERT: begin
                if (startFall) begin
                    // New command aborts: converter restarts on new sample
                    state_d.held  = sampleCode;                 // see RQ10
                    state_d.count = 16'(CONV_LEN);
                end else if (state_q.count <= 16'h0001) begin
                    state_d.phase = UPDATE;                     // see RQ12
                end else begin
                    state_d.count = state_q.count - 16'h0001;
                end
            end
            UPDATE: begin
                // Register first, busy released one cycle later
                state_d.result = state_q.held;                  // see RQ12
                state_d.phase  = IDLE;
            end
            default: begin
                state_d.phase = IDLE;
            end
        endcase
        // Busy rises only after result register holds the new word
        if (state_q.phase == IDLE && !state_q.busyN) begin
            state_d.busyN = 1'b1;                               // see RQ1
        end
        // Output drive: word or byte chosen by byte select
        state_d.bus.data = state_q.result;                      // see RQ7
        if (ctl.byteSel) begin
            state_d.bus.data[BYTE_WIDTH-1:0] = state_q.result[BYTE_WIDTH-1:0]; // see RQ8
        end else begin
            state_d.bus.data[BYTE_WIDTH-1:0] = state_q.result[15:BYTE_WIDTH];  // see RQ8
        end
        // Readout rising edge and held level both keep bus enabled
        state_d.bus.oe = (outEn | readRise) ? 16'hFFFF : 16'h0000; // see RQ5 see RQ6
        if (!outEn) begin
            state_d.bus.oe = 16'h0000;                          // see RQ6
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q           <= '0;
            state_q.phase     <= IDLE;
            state_q.startPrev <= 1'b1;
            state_q.readPrev  <= 1'b1;
            state_q.result    <= RESULT_RESET;
            state_q.busyN     <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from flops
    assign busyN         = state_q.busyN;
    assign resultDataOut = state_q.bus.data;
    assign resultDataOe  = state_q.bus.oe;
endmodule : sar_adc_parallel_host_port

/* File: tb/sar_port_sva.sv */
// Assertions on the converter host port pins
`timescale 1ns/1ns
module sar_port_sva #(parameter int CONV_LEN = 8) (
    input wire logic        mclk, rst_b, selN, readConv, byteSel, busyN,
    input wire logic [15:0] sampleCode, resultDataIn, resultDataOut, resultDataOe
);
    int   lowCnt_q;
    logic startHi;
    // Either control high blocks a start
    assign startHi = selN | readConv;
    // Length of the current busy pulse
    always_ff @(posedge mclk or negedge rst_b)
        lowCnt_q <= !rst_b ? 0 : (busyN ? 0 : lowCnt_q + 1);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_oe_off: assert property ((selN || !readConv)[*4] |-> resultDataOe == 16'h0000)
        else $error("bus driven");
    a_oe_on: assert property ((!selN && readConv)[*4] |-> resultDataOe == 16'hFFFF)
        else $error("bus not driven");
    a_oe_whole: assert property (resultDataOe == 16'h0000 || resultDataOe == 16'hFFFF)
        else $error("partial bus");
    a_start_busy: assert property ($fell(startHi) ##1 !startHi[*2] |-> ##[0:4] !busyN)
        else $error("no start");
    a_idle_quiet: assert property (startHi[*8] ##0 busyN |=> busyN)
        else $error("spurious start");
    a_busy_len: assert property ($rose(busyN) |-> lowCnt_q >= CONV_LEN)
        else $error("busy too short");
    a_result_hold: assert property (busyN && $past(busyN) |-> $stable(resultDataOut[15:8]))
        else $error("result moved");
    a_upper_byte: assert property ((!byteSel)[*4] |-> resultDataOut[7:0] == resultDataOut[15:8])
        else $error("byte mux");
    c_start: cover property ($fell(busyN));
    c_done: cover property ($rose(busyN));
    c_low_byte: cover property (resultDataOe == 16'hFFFF && byteSel);
endmodule : sar_port_sva

/* File: tb/host_model.sv */
// Host model driving select, read/convert, byte select and the sample
`timescale 1ns/1ns
module host_model (
    input  wire logic        mclk,
    input  wire logic [15:0] busIn,
    output logic             selN, readConv, byteSel,
    output logic      [15:0] sampleCode
);
    // Select and read/convert idle high so nothing starts in reset
    initial begin
        selN = 1'b1;
        readConv = 1'b1;
        byteSel = 1'b0;
        sampleCode = 16'h0000;
    end
    // Inputs always change 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    // The later falling input is the trigger
    task automatic convert(input logic viaSel, input logic [15:0] code);
        sampleCode = code;
        readConv = !viaSel;
        selN = viaSel;
        step(1);
        selN = 1'b0;
        readConv = 1'b0;
        step(3);
        selN = 1'b1;
        readConv = 1'b1;
    endtask : convert
    // Select with read/convert high opens the bus
    task automatic read(input logic bs, output logic [15:0] data);
        byteSel = bs;
        selN = 1'b0;
        step(4);
        data = busIn;
        selN = 1'b1;
        // Let an edge pass so a second read cannot lower select in the same step
        step(1);
    endtask : read
endmodule : host_model

/* File: tb/tb_top.sv */
// Testbench for the converter host port
`timescale 1ns/1ns
module tb_top;
    localparam int CONV_LEN = 8;
    logic        mclk = 1'b0, rst_b = 1'b0, selN, readConv, byteSel, busyN;
    logic [15:0] sampleCode, busLvl, resultDataOut, resultDataOe, data;
    int          num_errors = 0, total_checks = 0, cycles = 0;
    // Floating bits show the inverse of the last value
    assign busLvl = resultDataOut ^ ~resultDataOe;
    always #20 mclk = ~mclk;
    host_model host (.mclk(mclk), .busIn(busLvl), .selN(selN), .readConv(readConv),
        .byteSel(byteSel), .sampleCode(sampleCode));
    sar_adc_parallel_host_port #(.CONV_LEN(CONV_LEN)) dut (.mclk(mclk), .rst_b(rst_b),
        .selN(selN), .readConv(readConv), .byteSel(byteSel), .sampleCode(sampleCode),
        .busyN(busyN), .resultDataIn(busLvl), .resultDataOut(resultDataOut),
        .resultDataOe(resultDataOe));
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (!ok) begin
            num_errors++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic finish_test;
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // Bounded wait so a stuck busy cannot hang the run
    task automatic wait_busy(input logic lvl);
        for (int n = 0; n < 40 && busyN !== lvl; n++)
            host.step(1);
        chk(busyN === lvl, "busy level");
    endtask : wait_busy
    task automatic check_result(input logic [15:0] code);
        wait_busy(1'b0);
        wait_busy(1'b1);
        host.read(1'b1, data);
        chk(data === code, "word read");
        host.read(1'b0, data);
        chk(data === {code[15:8], code[15:8]}, "upper byte");
        host.step(4);
        chk(resultDataOe === 16'h0000, "bus floats");
    endtask : check_result
    task automatic t_sel_start;
        host.convert(1'b1, 16'h8000);
        check_result(16'h8000);
    endtask : t_sel_start
    task automatic t_rc_start;
        host.convert(1'b0, 16'h7FFF);
        check_result(16'h7FFF);
    endtask : t_rc_start
    // Second command lands while busy, so the first result is lost
    task automatic t_abort;
        host.convert(1'b1, 16'h1234);
        wait_busy(1'b0);
        host.convert(1'b0, 16'hFFFF);
        chk(busyN === 1'b0, "abort dropped busy");
        check_result(16'hFFFF);
    endtask : t_abort
    // Reset for 3 cycles, then the scenarios
    initial begin
        repeat (3) @(posedge mclk);
        #1 rst_b = 1'b1;
        host.step(3);
        t_sel_start();
        t_rc_start();
        t_abort();
        finish_test();
    end
    // Cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            finish_test();
        end
    end
endmodule : tb_top
bind sar_adc_parallel_host_port sar_port_sva #(.CONV_LEN(CONV_LEN)) u_sva (.mclk(mclk),
    .rst_b(rst_b), .selN(selN), .readConv(readConv), .byteSel(byteSel), .busyN(busyN),
    .sampleCode(sampleCode), .resultDataIn(resultDataIn), .resultDataOut(resultDataOut),
    .resultDataOe(resultDataOe));
